// [tks_pkg.sv]
// ============================================================
// shared constants for the timekeeping nv sram
package tks_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int RAM_WORDS = 32768;
    // clock register byte addresses
    localparam logic [14:0] ADDR_CONTROL = 15'h7FF8;
    localparam logic [14:0] ADDR_SECONDS = 15'h7FF9;
    localparam logic [14:0] ADDR_MINUTES = 15'h7FFA;
    localparam logic [14:0] ADDR_HOURS = 15'h7FFB;
    localparam logic [14:0] ADDR_WEEKDAY = 15'h7FFC;
    localparam logic [14:0] ADDR_DATE = 15'h7FFD;
    localparam logic [14:0] ADDR_MONTH = 15'h7FFE;
    localparam logic [14:0] ADDR_YEAR = 15'h7FFF;
    localparam logic [11:0] CLK_REGION = 12'hFFF; // addr[14:3] of the clock block
    // field positions
    localparam int BIT_LOAD = 7;      // clock_control: time load
    localparam int BIT_HOLD = 6;      // clock_control: snapshot hold
    localparam int BIT_HALT = 7;      // seconds: crystal halt
    localparam int BIT_FTEST = 6;     // weekday: frequency test
    // field masks of counting bits per register
    localparam logic [7:0] MASK_SEC = 8'h7F;
    localparam logic [7:0] MASK_MIN = 8'h7F;
    localparam logic [7:0] MASK_HOUR = 8'h3F;
    localparam logic [7:0] MASK_WDAY = 8'h07;
    localparam logic [7:0] MASK_DATE = 8'h3F;
    localparam logic [7:0] MASK_MONTH = 8'h1F;
    localparam logic [7:0] MASK_YEAR = 8'hFF;
    // bcd limits
    localparam logic [7:0] BCD_59 = 8'h59;
    localparam logic [7:0] BCD_23 = 8'h23;
    localparam logic [7:0] BCD_07 = 8'h07;
    localparam logic [7:0] BCD_12 = 8'h12;
    localparam logic [7:0] BCD_99 = 8'h99;
    localparam logic [7:0] BCD_01 = 8'h01;
    localparam logic [7:0] BCD_00 = 8'h00;
    localparam logic [7:0] BCD_02 = 8'h02;
    localparam logic [7:0] BCD_28 = 8'h28;
    localparam logic [7:0] BCD_29 = 8'h29;
    localparam logic [7:0] BCD_30 = 8'h30;
    localparam logic [7:0] BCD_31 = 8'h31;
    // timing
    localparam int CLK_HZ = 10_000_000;
    localparam int TEST_HZ = 512;
    localparam int TEST_TICKS = 32768 / TEST_HZ;   // crystal ticks per full test period... see top
    localparam int HOLDOFF_TICKS = 1;
    typedef enum logic [1:0] {
        TKS_RUN,
        TKS_FROZEN,
        TKS_LOADING
    } tks_mode_e;
endpackage

// [tks_sync.sv]
`timescale 1ns/1ps
// ============================================================
// two-stage synchroniser for one asynchronous level
module tks_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic din,
    output logic dout
);
    logic stage1;
    logic next_stage1;
    logic next_dout;

    // first stage only feeds the second
    always_comb begin
        next_stage1 = din;
        next_dout = stage1;
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            stage1 <= RESET_VAL;
            dout <= RESET_VAL;
        end else begin
            stage1 <= next_stage1;
            dout <= next_dout;
        end
    end
endmodule // tks_sync

// [tks_bcd_inc.sv]
`timescale 1ns/1ps
// ============================================================
// one bcd counter field: increments with wrap, flags carry
module tks_bcd_inc (
    input wire logic [7:0] value,
    input wire logic [7:0] mask,
    input wire logic [7:0] max_val,
    input wire logic [7:0] min_val,
    input wire logic inc,
    output logic [7:0] result,
    output logic carry
);
    logic [7:0] field;
    logic [3:0] low_next;

    // bcd increment of the counting bits, spare bits kept
    always_comb begin
        field = value & mask;
        low_next = field[3:0] + 4'h1;
        result = value;
        carry = 1'b0;
        if (inc) begin
            if (field >= max_val) begin
                result = (value & ~mask) | min_val;
                carry = 1'b1;
            end else if (field[3:0] >= 4'h9) begin
                result = (value & ~mask) | ((({field[7:4] + 4'h1, 4'h0}) & mask));
            end else begin
                result = (value & ~mask) | ({field[7:4], low_next} & mask);
            end
        end
    end
endmodule // tks_bcd_inc

// [tks_nvram_rtc.sv]
`timescale 1ns/1ps
// ============================================================
// timekeeping static ram: 32k bytes, top eight bytes are a bcd clock
// Functional notes
// - 32k x 8 array; 7FF8..7FFF are clock registers, not storage.
// - all time fields are bcd, hours in 24-hour form.
// - days per month and leap years handled, correct through 2099.
// - hold bit (control bit 6) stops copies to visible registers.
// - while frozen, visible time stays; inner counters keep running.
// - after hold clears, all visible registers refresh together within a second.
// - load bit (control bit 7) stops updates so host can write time.
// - clearing load bit copies written values into counters, resumes counting.
// - seconds bit 7 halts the crystal; changeable any time.
// - weekday bit 6 with crystal running toggles seconds lsb at 512 Hz.
// - sustained seconds read shows the 512 Hz toggle on data lsb.
// - non-clock bits of 7FF8 are plain read/write; in 7FF9..7FFF, halt and test aside, a write sticks only if made with load set.
// - write strobe high with chip select low is read mode.
// - data pins driven only when select and output enable low in read.
// - reads ripple through; address change brings the new byte.
// - timekeeping continues regardless of host accesses.
// - supply out of tolerance deselects device; pins high impedance.
// - select and write strobe both low is write, whatever output enable.
// - power-fail output low during power failure until supply returns.
module tks_nvram_rtc
    import tks_pkg::*;
#(
    parameter int ADDR_BITS = ADDR_W,
    parameter int XTAL_HZ = 32768
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [14:0] addr_pins,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic write_n,
    input wire logic [7:0] data_pins_in,
    output logic [7:0] data_pins_out,
    output logic data_pins_oe,
    input wire logic xtal_clk,
    input wire logic supply_ok,
    output logic power_fail_flag_n
);
    localparam int HALF_TEST = XTAL_HZ / (2 * TEST_HZ);
    localparam int SEC_TICKS = XTAL_HZ;
    // ============================================================
    // parameter checks
    // decode assumes the full 15-bit array
    if (ADDR_BITS != ADDR_W) begin : g_bad_addr
        $error("address width must match the array");
    end
    // test toggle needs whole crystal ticks per half period
    if (XTAL_HZ % (2 * TEST_HZ) != 0) begin : g_bad_ratio
        $error("crystal rate not a multiple of twice the test rate");
    end
    // seconds prescaler is sixteen bits wide
    if ($clog2(XTAL_HZ) > 16) begin : g_bad_rate
        $error("crystal rate too high for the prescaler");
    end

    // ============================================================
    // pin synchronisers
    logic [14:0] addr_s;
    logic [7:0] din_s;
    logic cs_n_s, oe_n_s, we_n_s, xtal_s, sup_s;
    // every pin passes two flops; a read answers on the third edge
    genvar gi;
    generate
        for (gi = 0; gi < 15; gi++) begin : g_addr
            tks_sync u_a (.mclk(mclk), .rstn(rstn), .din(addr_pins[gi]), .dout(addr_s[gi]));
        end
        for (gi = 0; gi < 8; gi++) begin : g_data
            tks_sync u_d (.mclk(mclk), .rstn(rstn), .din(data_pins_in[gi]), .dout(din_s[gi]));
        end
    endgenerate
    tks_sync #(.RESET_VAL(1'b1)) u_cs (.mclk(mclk), .rstn(rstn), .din(chip_sel_n), .dout(cs_n_s));
    tks_sync #(.RESET_VAL(1'b1)) u_oe (.mclk(mclk), .rstn(rstn), .din(out_en_n), .dout(oe_n_s));
    tks_sync #(.RESET_VAL(1'b1)) u_we (.mclk(mclk), .rstn(rstn), .din(write_n), .dout(we_n_s));
    tks_sync u_xt (.mclk(mclk), .rstn(rstn), .din(xtal_clk), .dout(xtal_s));
    // supply reads good during reset, so no false power fail follows it
    tks_sync #(.RESET_VAL(1'b1)) u_sp (.mclk(mclk), .rstn(rstn), .din(supply_ok), .dout(sup_s));

    // ============================================================
    // access decode
    logic rd_cyc, wr_cyc, is_clk, wr_prev, wr_pulse;
    always_comb begin
        // write whenever supply good and select and strobe low
        wr_cyc = sup_s && !cs_n_s && !we_n_s;
        rd_cyc = sup_s && !cs_n_s && we_n_s;
        is_clk = (addr_s[14:3] == CLK_REGION);
        // one store per write cycle, from whichever strobe falls last
        wr_pulse = wr_cyc && !wr_prev;
    end

    // ============================================================
    // ram storage
    // plain storage below the clock block
    logic [7:0] mem [0:RAM_WORDS-1];
    logic mem_we;
    logic [14:0] mem_addr;
    logic [7:0] mem_data;
    // write enable and operands for the array, one write per cycle
    always_comb begin
        mem_we = wr_pulse && !is_clk;
        mem_addr = addr_s;
        mem_data = din_s;
    end

    // the array itself, not reset: contents survive a reset
    always_ff @(posedge mclk) begin
        if (mem_we) begin
            mem[mem_addr] <= mem_data;
        end
    end

    // ============================================================
    // crystal tick and test toggle
    // halt also stops the prescaler, so a restart resumes mid-second
    logic xtal_d, tick;
    logic [15:0] sec_cnt, next_sec_cnt;
    logic [9:0] ft_cnt, next_ft_cnt;
    logic ft_phase, next_ft_phase;
    logic sec_pulse;
    logic [7:0] cnt [0:7];     // running counters (index 0 unused)
    logic [7:0] vis [0:7];     // host visible registers
    logic [7:0] next_cnt [0:7];
    logic [7:0] next_vis [0:7];
    logic halted;
    always_comb begin
        halted = cnt[1][BIT_HALT];
        tick = xtal_s && !xtal_d && !halted;
        next_sec_cnt = sec_cnt;
        next_ft_cnt = ft_cnt;
        next_ft_phase = ft_phase;
        sec_pulse = 1'b0;
        if (tick) begin
            if (sec_cnt == 16'(SEC_TICKS - 1)) begin
                next_sec_cnt = '0;
                sec_pulse = 1'b1;
            end else begin
                next_sec_cnt = sec_cnt + 16'h0001;
            end
            if (ft_cnt == 10'(HALF_TEST - 1)) begin
                next_ft_cnt = '0;
                next_ft_phase = !ft_phase;
            end else begin
                next_ft_cnt = ft_cnt + 10'h001;
            end
        end
    end

    // ============================================================
    // bcd calendar chain
    // bcd counting, 24-hour form
    logic c_sec, c_min, c_hour, c_date, c_month;
    logic [7:0] r_sec, r_min, r_hour, r_wday, r_date, r_month, r_year;
    logic [7:0] last_day;
    logic [7:0] yr;
    logic leap;
    always_comb begin
        yr = cnt[7];
        // leap every fourth year, 2000 and 2100 window
        // year 00 is taken as leap; the two-digit year never reaches 2100
        leap = (yr[4] == 1'b0) ? (yr[1:0] == 2'b00) : (yr[1:0] == 2'b10);
        case (cnt[6] & MASK_MONTH)
            BCD_02: last_day = leap ? BCD_29 : BCD_28;
            8'h04, 8'h06, 8'h09, 8'h11: last_day = BCD_30;
            default: last_day = BCD_31;
        endcase
    end
    // one incrementer per field, carries ripple from seconds to year
    tks_bcd_inc u_sec (.value(cnt[1]), .mask(MASK_SEC), .max_val(BCD_59), .min_val(BCD_00),
        .inc(sec_pulse), .result(r_sec), .carry(c_sec));
    tks_bcd_inc u_min (.value(cnt[2]), .mask(MASK_MIN), .max_val(BCD_59), .min_val(BCD_00),
        .inc(c_sec), .result(r_min), .carry(c_min));
    tks_bcd_inc u_hour (.value(cnt[3]), .mask(MASK_HOUR), .max_val(BCD_23), .min_val(BCD_00),
        .inc(c_min), .result(r_hour), .carry(c_hour));
    // weekday rides the hour carry beside the date
    tks_bcd_inc u_wday (.value(cnt[4]), .mask(MASK_WDAY), .max_val(BCD_07), .min_val(BCD_01),
        .inc(c_hour), .result(r_wday), .carry());
    tks_bcd_inc u_date (.value(cnt[5]), .mask(MASK_DATE), .max_val(last_day), .min_val(BCD_01),
        .inc(c_hour), .result(r_date), .carry(c_date));
    tks_bcd_inc u_month (.value(cnt[6]), .mask(MASK_MONTH), .max_val(BCD_12), .min_val(BCD_01),
        .inc(c_date), .result(r_month), .carry(c_month));
    tks_bcd_inc u_year (.value(cnt[7]), .mask(MASK_YEAR), .max_val(BCD_99), .min_val(BCD_00),
        .inc(c_month), .result(r_year), .carry());

    // ============================================================
    // double buffer control
    // cnt runs unless halted; vis is what the host reads and writes
    logic hold, load, load_d, frozen;
    logic [2:0] widx;
    always_comb begin
        hold = vis[0][BIT_HOLD];
        load = vis[0][BIT_LOAD];
        // either bit keeps the visible copy still
        frozen = hold || load;
        widx = addr_s[2:0];
        for (int i = 0; i < 8; i++) begin
            next_cnt[i] = cnt[i];
            next_vis[i] = vis[i];
        end
        // counters advance whatever the host does
        next_cnt[1] = r_sec;
        next_cnt[2] = r_min;
        next_cnt[3] = r_hour;
        next_cnt[4] = r_wday;
        next_cnt[5] = r_date;
        next_cnt[6] = r_month;
        next_cnt[7] = r_year;
        // load release copies visible values into counters
        if (load_d && !load) begin
            for (int i = 1; i < 8; i++)
                next_cnt[i] = vis[i];
        end
        // visible copy keeps the frozen time
        // all visible registers refresh in one update
        if (!frozen && !(load_d && !load)) begin
            for (int i = 1; i < 8; i++)
                next_vis[i] = next_cnt[i];
        end
        // halt bit writable at any time, reaches counter at once
        if (wr_pulse && is_clk) begin
            next_vis[widx] = din_s;
            if (widx == ADDR_SECONDS[2:0])
                next_cnt[1][BIT_HALT] = din_s[BIT_HALT];
            if (widx == ADDR_WEEKDAY[2:0])
                next_cnt[4][BIT_FTEST] = din_s[BIT_FTEST];
        end
    end

    // registers only; all decisions sit in the block above
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            xtal_d <= 1'b0;
            wr_prev <= 1'b0;
            load_d <= 1'b0;
            sec_cnt <= '0;
            ft_cnt <= '0;
            ft_phase <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                cnt[i] <= BCD_00;
                vis[i] <= BCD_00;
            end
        end else begin
            xtal_d <= xtal_s;
            wr_prev <= wr_cyc;
            load_d <= load;
            sec_cnt <= next_sec_cnt;
            ft_cnt <= next_ft_cnt;
            ft_phase <= next_ft_phase;
            for (int i = 0; i < 8; i++) begin
                cnt[i] <= next_cnt[i];
                vis[i] <= next_vis[i];
            end
        end
    end

    // ============================================================
    // read path and power fail output
    logic [7:0] rd_byte, next_dout;
    logic next_oe;
    logic next_pf_n;
    always_comb begin
        if (is_clk) begin
            rd_byte = vis[addr_s[2:0]];
            // seconds read shows the test toggle on data lsb
            // the toggle replaces only bit 0 of the seconds byte
            if (addr_s == ADDR_SECONDS && vis[4][BIT_FTEST] && !halted)
                rd_byte[0] = ft_phase;
        end else begin
            rd_byte = mem[addr_s];
        end
        // drive only in read with output enable low
        next_oe = rd_cyc && !oe_n_s;
        next_dout = next_oe ? rd_byte : BCD_00;
        // power fail flag follows the synced supply
        next_pf_n = sup_s;
    end

    // pins lag the address by the two sync edges and this register
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            data_pins_out <= 8'h00;
            data_pins_oe <= 1'b0;
            power_fail_flag_n <= 1'b1;
        end else begin
            data_pins_out <= next_dout;
            data_pins_oe <= next_oe;
            // flag low while supply is out of band
            power_fail_flag_n <= next_pf_n;
        end
    end
endmodule // tks_nvram_rtc

// [tks_nvram_rtc_checker.sv]
`timescale 1ns/1ps
// ============================================================
// port checks for the timekeeping sram
module tks_nvram_rtc_checker
    import tks_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [14:0] addr_pins,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic write_n,
    input wire logic [7:0] data_pins_out,
    input wire logic data_pins_oe,
    input wire logic supply_ok,
    input wire logic power_fail_flag_n
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    // ============================================================
    // bus cycle shapes
    sequence s_read_req;
        !chip_sel_n && !out_en_n && write_n && supply_ok;
    endsequence
    sequence s_ram_read;
        !chip_sel_n && !out_en_n && write_n && supply_ok && $stable(addr_pins) && addr_pins[14:3] != CLK_REGION;
    endsequence
    // ============================================================
    // data pin drive, allowing for the input synchronisers
    a_desel_quiet: assert property (chip_sel_n [*5] |-> !data_pins_oe)
        else $error("data pins driven while deselected");
    a_write_quiet: assert property ((!chip_sel_n && !write_n) [*5] |-> !data_pins_oe)
        else $error("data pins driven during a write");
    a_read_drives: assert property (s_read_req [*6] |-> data_pins_oe)
        else $error("read cycle left data pins undriven");
    a_idle_zero: assert property (!data_pins_oe |-> data_pins_out == 8'h00)
        else $error("read data not cleared while released");
    a_ram_ripple: assert property (s_ram_read [*7] |-> $stable(data_pins_out))
        else $error("ram read data moved with address steady");
    // ============================================================
    // supply failure
    a_fail_quiet: assert property ((!supply_ok) [*5] |-> !data_pins_oe)
        else $error("data pins driven during power fail");
    a_fail_flag_on: assert property ($fell(supply_ok) |-> ##[1:5] !power_fail_flag_n)
        else $error("power fail flag late");
    a_fail_flag_hold: assert property ((!supply_ok) [*5] |-> !power_fail_flag_n)
        else $error("power fail flag dropped early");
    a_fail_flag_off: assert property (supply_ok [*6] |-> power_fail_flag_n)
        else $error("power fail flag stuck with good supply");
endmodule // tks_nvram_rtc_checker

bind tks_nvram_rtc tks_nvram_rtc_checker u_chk (.mclk(mclk), .rstn(rstn), .addr_pins(addr_pins),
    .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_n(write_n), .data_pins_out(data_pins_out),
    .data_pins_oe(data_pins_oe), .supply_ok(supply_ok), .power_fail_flag_n(power_fail_flag_n));

// [tks_host_model.sv]
`timescale 1ns/1ps
// ============================================================
// host bus master: changes strobes just after mclk, holds whole cycles
module tks_host_model (
    input wire logic mclk,
    input wire logic [7:0] data_pins_out,
    input wire logic data_pins_oe,
    output logic [14:0] addr_pins,
    output logic chip_sel_n,
    output logic out_en_n,
    output logic write_n,
    output logic [7:0] host_data,
    output logic host_oe
);
    // idle bus from time zero
    initial begin
        addr_pins = 15'h0000;
        chip_sel_n = 1'b1;
        out_en_n = 1'b1;
        write_n = 1'b1;
        host_oe = 1'b0;
    end
    // wait edges, then step just past the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // write held past the sync, gap before the next cycle
    task automatic wr(input logic [14:0] a, input logic [7:0] d, input logic oe_lo);
        addr_pins = a;
        host_data = d;
        host_oe = 1'b1;
        out_en_n = ~oe_lo;
        chip_sel_n = 1'b0;
        write_n = 1'b0;
        cyc(6);
        chip_sel_n = 1'b1;
        write_n = 1'b1;
        out_en_n = 1'b1;
        cyc(1);
        host_oe = 1'b0;
        cyc(3);
    endtask
    // read with strobe high, sampled once settled
    task automatic rd(input logic [14:0] a, output logic [7:0] d, output logic oe);
        addr_pins = a;
        chip_sel_n = 1'b0;
        out_en_n = 1'b0;
        cyc(6);
        d = data_pins_out;
        oe = data_pins_oe;
        chip_sel_n = 1'b1;
        out_en_n = 1'b1;
        cyc(5);
    endtask
    // sustained read, counts changes of the data lsb
    task automatic watch_lsb(input logic [14:0] a, input int n, output int flips);
        logic last;
        flips = 0;
        addr_pins = a;
        chip_sel_n = 1'b0;
        out_en_n = 1'b0;
        cyc(6);
        last = data_pins_out[0];
        repeat (n) begin
            cyc(1);
            if (data_pins_out[0] !== last) flips++;
            last = data_pins_out[0];
        end
        chip_sel_n = 1'b1;
        out_en_n = 1'b1;
        cyc(5);
    endtask
endmodule // tks_host_model

// [timekeeping_nv_sram_tb_top.sv]
`timescale 1ns/1ps
// ============================================================
// self-checking bench for the timekeeping sram
module timekeeping_nv_sram_tb_top;
    import tks_pkg::*;
    localparam int XTAL_SIM = 1024;
    localparam int FLIPS = 400 * 100 / 2006; // lsb changes in 400 cycles, one per crystal period
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic xtal_clk = 1'b0;
    logic supply_ok = 1'b1;
    logic [14:0] addr_pins;
    logic chip_sel_n, out_en_n, write_n, host_oe, data_pins_oe, power_fail_flag_n;
    logic [7:0] host_data, data_pins_out, data_pins_in;
    logic [7:0] idle_pat = 8'hA5;
    int error_cnt = 0;
    int tests_run = 0;
    // clocks: crystal unrelated in phase to mclk
    always #50 mclk = ~mclk;
    always #1003 xtal_clk = ~xtal_clk;
    // released bus shows a changing pattern
    always @(posedge mclk) idle_pat <= ~idle_pat;
    assign data_pins_in = host_oe ? host_data : (data_pins_oe ? data_pins_out : idle_pat);
    tks_host_model host (.mclk(mclk), .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe),
        .addr_pins(addr_pins), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_n(write_n),
        .host_data(host_data), .host_oe(host_oe));
    tks_nvram_rtc #(.XTAL_HZ(XTAL_SIM)) dut (.mclk(mclk), .rstn(rstn), .addr_pins(addr_pins),
        .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_n(write_n), .data_pins_in(data_pins_in),
        .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe), .xtal_clk(xtal_clk),
        .supply_ok(supply_ok), .power_fail_flag_n(power_fail_flag_n));
    // ============================================================
    // compare and report
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic rdchk(input logic [14:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic oe;
        host.rd(a, d, oe);
        check({7'h00, oe}, 8'h01);
        check(d, exp);
    endtask
    // ============================================================
    // scenarios
    task automatic t_ram();
        host.wr(15'h0000, 8'h11, 1'b0);
        host.wr(15'h7FF7, 8'hEE, 1'b1);
        rdchk(15'h0000, 8'h11);
        rdchk(15'h7FF7, 8'hEE);
    endtask
    task automatic t_power();
        logic [7:0] d;
        logic oe;
        host.wr(15'h0010, 8'h3C, 1'b0);
        supply_ok = 1'b0;
        host.cyc(6);
        check({7'h00, power_fail_flag_n}, 8'h00);
        host.wr(15'h0010, 8'hC3, 1'b0);
        host.rd(15'h0010, d, oe);
        check({7'h00, oe}, 8'h00);
        supply_ok = 1'b1;
        host.cyc(6);
        check({7'h00, power_fail_flag_n}, 8'h01);
        rdchk(15'h0010, 8'h3C);
    endtask
    task automatic t_rollover();
        logic [7:0] ld [7] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'hE2, 8'h04};
        logic [7:0] ex [7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h29, 8'hE2, 8'h04};
        logic [7:0] d;
        logic oe;
        int n;
        host.wr(ADDR_CONTROL, 8'h80, 1'b0);
        for (int i = 0; i < 7; i++) host.wr(ADDR_SECONDS + 15'(i), ld[i], 1'b0);
        host.wr(ADDR_CONTROL, 8'h00, 1'b0);
        n = 0;
        d = 8'h59;
        while (d !== 8'h00 && n < 2500) begin
            host.rd(ADDR_SECONDS, d, oe);
            n++;
        end
        if (d !== 8'h00) begin
            check(d, 8'h00);
            complete_run();
        end
        host.wr(ADDR_CONTROL, 8'h40, 1'b0);
        for (int i = 0; i < 7; i++) rdchk(ADDR_SECONDS + 15'(i), ex[i]);
        host.cyc(21000);
        rdchk(ADDR_SECONDS, 8'h00);
        host.wr(ADDR_CONTROL, 8'h00, 1'b0);
        rdchk(ADDR_SECONDS, 8'h01);
    endtask
    task automatic t_ftest();
        int flips;
        host.wr(ADDR_CONTROL, 8'h80, 1'b0);
        host.wr(ADDR_WEEKDAY, 8'h41, 1'b0);
        host.wr(ADDR_CONTROL, 8'h00, 1'b0);
        host.watch_lsb(ADDR_SECONDS, 400, flips);
        check({7'h00, flips >= FLIPS - 3 && flips <= FLIPS + 3}, 8'h01);
        host.wr(ADDR_CONTROL, 8'h80, 1'b0);
        host.wr(ADDR_WEEKDAY, 8'h01, 1'b0);
        host.wr(ADDR_CONTROL, 8'h00, 1'b0);
    endtask
    task automatic t_halt();
        host.wr(ADDR_CONTROL, 8'h80, 1'b0);
        host.wr(ADDR_SECONDS, 8'hB0, 1'b0);
        host.wr(ADDR_CONTROL, 8'h00, 1'b0);
        host.cyc(21000);
        rdchk(ADDR_SECONDS, 8'hB0);
    endtask
    task automatic t_reset();
        int flips;
        host.watch_lsb(15'h0000, 20, flips);
        check(8'(flips), 8'h00);
        rstn = 1'b0;
        host.cyc(4);
        rstn = 1'b1;
        host.cyc(2);
        check({7'h00, power_fail_flag_n}, 8'h01);
        host.cyc(2);
        rdchk(ADDR_SECONDS, 8'h00);
        rdchk(15'h0000, 8'h11);
    endtask
    // ============================================================
    // main sequence: reset for 8 cycles, then the scenarios
    initial begin
        host.cyc(8);
        rstn = 1'b1;
        host.cyc(4);
        t_ram();
        t_power();
        t_rollover();
        t_ftest();
        t_halt();
        t_reset();
        complete_run();
    end
endmodule // timekeeping_nv_sram_tb_top
